// ---- pkg/gfc_params.svh ----
/*
  Constants of the gated frequency counter: register addresses, field
  positions, reset values, field codes and timing figures.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef GFC_PARAMS_SVH
`define GFC_PARAMS_SVH

// ============================================================
// Register addresses
`define GFC_ADDR_MODE      8'h1E
`define GFC_ADDR_GTIME     8'h1F
`define GFC_ADDR_CHAN      8'h20
`define GFC_ADDR_STAT      8'h21
`define GFC_ADDR_CTRL      8'h23
`define GFC_ADDR_DATA      8'h24

// ============================================================
// Field positions
`define GFC_CTRL_CLR_BIT   0
`define GFC_CTRL_START_BIT 1
`define GFC_STAT_OPEN_BIT  0

// ============================================================
// Reset values
`define GFC_MODE_RST       2'h0
`define GFC_GTIME_RST      2'h0
`define GFC_CHAN_RST       2'h0
`define GFC_COUNT_RST      16'h0000

// ============================================================
// Field codes
`define GFC_MODE_EXT       2'h0
`define GFC_MODE_DIRECT    2'h1
`define GFC_MODE_HALVED    2'h2
`define GFC_MODE_FM_FULL   2'h3
`define GFC_GT_1MS         2'h0
`define GFC_GT_4MS         2'h1
`define GFC_GT_8MS         2'h2
`define GFC_GT_OPEN        2'h3
`define GFC_CHAN_A         2'h1
`define GFC_CHAN_B         2'h2
`define GFC_CNT_MAX        16'hFFFF

// ============================================================
// Timing
`define GFC_MCLK_HZ        25000000
`define GFC_REF_1K_HZ      1000
`define GFC_REF_100K_HZ    100000
`define GFC_REF_900K_HZ    900000
// Gate lengths in 1-kHz reference periods (1 ms each)
`define GFC_GATE_1MS       4'h1
`define GFC_GATE_4MS       4'h4
`define GFC_GATE_8MS       4'h8

`endif

// ---- pkg/gfc_pkg.sv ----
/*
  Types of the gated frequency counter: states, register bus carrier,
  pin group and the core state record.
  Assumes gfc_params.svh is reachable on the include path.
*/
`include "gfc_params.svh"

package gfc_pkg;

    // ============================================================
    // Gate sequencer states
    typedef enum logic [2:0] {
        GFC_IDLE,
        GFC_ARM,
        GFC_TIMED,
        GFC_OPEN,
        GFC_EXT_ARM,
        GFC_EXT_OPEN
    } gfc_state_e;

    // ============================================================
    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } gfc_bus_req_s;

    // Input pins, raw
    typedef struct packed {
        logic halvedIn;
        logic directIn;
        logic gateA;
        logic gateB;
    } gfc_pins_s;

    // ============================================================
    // Core state record
    typedef struct packed {
        gfc_state_e  fsm;
        logic [1:0]  modeSel;
        logic [1:0]  gtimeSel;
        logic [1:0]  chanSel;
        logic        gateFlag;
        logic [3:0]  msLeft;
        logic [15:0] count;
        logic        prevIn;
        logic        halvedPrev;
        logic        halfTgl;
        logic        gatePrev;
        logic [15:0] xfer;
        logic [15:0] rdata;
    } gfc_core_s;

endpackage : gfc_pkg

// ---- src/gfc_freq_counter.sv ----
/*
  Gated 16-bit frequency counter: internally timed gate counting of two
  input pins, and external-gate counting of an internal reference.
  Assumes a register master on mclk with one-cycle strobes and that
  the input and gate pins are asynchronous to mclk.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "gfc_params.svh"

module gfc_freq_counter
    import gfc_pkg::*;
#(
    parameter int unsigned CLK_HZ = `GFC_MCLK_HZ
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Register bus
    input  wire gfc_bus_req_s busReq,
    output logic      [15:0]  busRdata,
    // Pins
    input  wire gfc_pins_s    pins,
    // Status
    output logic              gateOpen,
    output logic      [15:0]  xferBuf
);
    // ============================================================
    // Synchronised pins and references
    logic [3:0] pinSync;
    logic [2:0] refLvl;
    logic [2:0] refTick;
    logic       halvedS;
    logic       directS;
    logic       gateAS;
    logic       gateBS;

    gfc_sync #(
        .W(4)
    ) uSync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pinIn   ({pins.halvedIn, pins.directIn, pins.gateA, pins.gateB}),
        .pinSync (pinSync)
    );

    assign {halvedS, directS, gateAS, gateBS} = pinSync;

    gfc_ref_gen #(
        .CLK_HZ(CLK_HZ)
    ) uRef (
        .mclk    (mclk),
        .reset_n (reset_n),
        .refLvl  (refLvl),
        .refTick (refTick)
    );

    // ============================================================
    // State
    gfc_core_s st_q;
    gfc_core_s st_d;

    function automatic logic [3:0] gateLen(input logic [1:0] sel);
        logic [3:0] len;
        len = `GFC_GATE_1MS;
        if (sel == `GFC_GT_4MS) begin
            len = `GFC_GATE_4MS;
        end else if (sel == `GFC_GT_8MS) begin
            len = `GFC_GATE_8MS;
        end
        return len;
    endfunction : gateLen

    // ============================================================
    // Next state
    always_comb begin
        logic wrCtrl;
        logic startW;
        logic clrW;
        logic wrGt;
        logic openNew;
        logic ifMode;
        logic gateNow;
        logic src;
        logic gateSel;
        logic gateRise;
        logic cntEdge;
        logic tick1k;
        wrCtrl   = 1'b0;
        startW   = 1'b0;
        clrW     = 1'b0;
        wrGt     = 1'b0;
        openNew  = 1'b0;
        ifMode   = 1'b0;
        gateNow  = 1'b0;
        src      = 1'b0;
        gateSel  = 1'b0;
        gateRise = 1'b0;
        cntEdge  = 1'b0;
        tick1k   = refTick[0];
        st_d     = st_q;

        // Register writes; writing 0 to a control bit does nothing
        wrCtrl = busReq.wr && (busReq.addr == `GFC_ADDR_CTRL);
        startW = wrCtrl && busReq.wdata[`GFC_CTRL_START_BIT];
        clrW   = wrCtrl && busReq.wdata[`GFC_CTRL_CLR_BIT];
        wrGt   = busReq.wr && (busReq.addr == `GFC_ADDR_GTIME);
        if (busReq.wr && (busReq.addr == `GFC_ADDR_MODE)) begin
            st_d.modeSel = busReq.wdata[1:0];
        end else if (wrGt) begin
            st_d.gtimeSel = busReq.wdata[1:0];
        end else if (busReq.wr && (busReq.addr == `GFC_ADDR_CHAN)) begin
            st_d.chanSel = busReq.wdata[1:0];
        end

        ifMode  = (st_q.modeSel != `GFC_MODE_EXT);
        // Held-open starts only on a change into the open code, so rewriting
        // the same code does not reopen a gate that a start has closed
        openNew = wrGt && (busReq.wdata[1:0] == `GFC_GT_OPEN)
                  && (st_q.gtimeSel != `GFC_GT_OPEN);

        // Halved pin divided by two before counting in GFC_MODE_HALVED; GFC_MODE_FM_FULL counts it undivided
        // The divider also runs while the gate is closed, so its phase is free
        st_d.halvedPrev = halvedS;
        if (halvedS && !st_q.halvedPrev) begin
            st_d.halfTgl = ~st_q.halfTgl;
        end

        // Counted source: a deselected pin reads low, so counting stops
        // External mode has no use for the gate time, so that field picks the
        // reference; codes 10 and 11 both give the fastest one
        if (st_q.fsm == GFC_EXT_OPEN) begin
            if (st_q.gtimeSel == `GFC_GT_1MS) begin
                src = refLvl[0];
            end else if (st_q.gtimeSel == `GFC_GT_4MS) begin
                src = refLvl[1];
            end else begin
                src = refLvl[2];
            end
        end else if (st_q.modeSel == `GFC_MODE_DIRECT) begin
            src = directS;
        end else if (st_q.modeSel == `GFC_MODE_HALVED) begin
            src = st_q.halfTgl;
        end else if (st_q.modeSel == `GFC_MODE_FM_FULL) begin
            src = halvedS;
        end else begin
            src = 1'b0;
        end

        // Edge memory is zero while closed, so a high input at opening
        // gives one count: tolerance +1/-0
        gateNow     = (st_q.fsm == GFC_TIMED) || (st_q.fsm == GFC_OPEN)
                      || (st_q.fsm == GFC_EXT_OPEN);
        cntEdge     = gateNow && src && !st_q.prevIn;
        st_d.prevIn = gateNow && src;

        // Counter: clear wins over a count in the same cycle
        // At FFFF the increment is held off, so the value cannot wrap
        if (clrW) begin
            st_d.count = `GFC_COUNT_RST;
        end else if (cntEdge && (st_q.count != `GFC_CNT_MAX)) begin
            st_d.count = st_q.count + 16'h0001;
        end

        // External gate pin
        // Changing the channel while the new pin is high reads as a rise;
        // software sets the channel before start
        if (st_q.chanSel == `GFC_CHAN_A) begin
            gateSel = gateAS;
        end else if (st_q.chanSel == `GFC_CHAN_B) begin
            gateSel = gateBS;
        end
        st_d.gatePrev = gateSel;
        gateRise      = gateSel && !st_q.gatePrev;

        // Gate sequencer
        // Start outranks every other gate event: a start in the cycle of a
        // closing edge re-arms the gate and is not lost
        if (startW) begin
            st_d.gateFlag = 1'b1;
            if (ifMode) begin
                st_d.fsm = GFC_ARM;
            end else begin
                st_d.fsm = GFC_EXT_ARM;
            end
        end else if (openNew && ifMode) begin
            st_d.fsm      = GFC_OPEN;
            st_d.gateFlag = 1'b1;
        end else begin
            case (st_q.fsm)
                GFC_ARM: begin
                    if (tick1k) begin
                        if (st_q.gtimeSel == `GFC_GT_OPEN) begin
                            // Start in held-open mode: gate just closes
                            st_d.fsm      = GFC_IDLE;
                            st_d.gateFlag = 1'b0;
                        end else begin
                            st_d.fsm    = GFC_TIMED;
                            st_d.msLeft = gateLen(st_q.gtimeSel);
                        end
                    end
                end
                GFC_TIMED: begin
                    if (tick1k) begin
                        // msLeft holds the ticks still to come; the last closes
                        st_d.msLeft = st_q.msLeft - 4'h1;
                        if (st_q.msLeft == 4'h1) begin
                            st_d.fsm      = GFC_IDLE;
                            st_d.gateFlag = 1'b0;
                        end
                    end
                end
                GFC_OPEN: begin
                    if (st_q.gtimeSel != `GFC_GT_OPEN) begin
                        st_d.fsm      = GFC_IDLE;
                        st_d.gateFlag = 1'b0;
                    end
                end
                GFC_EXT_ARM: begin
                    if (gateRise) begin
                        st_d.fsm = GFC_EXT_OPEN;
                    end
                end
                GFC_EXT_OPEN: begin
                    if (gateRise) begin
                        st_d.fsm      = GFC_IDLE;
                        st_d.gateFlag = 1'b0;
                    end
                end
                default: begin
                    st_d.fsm = GFC_IDLE;
                end
            endcase
        end

        // Read data stand for the one cycle after the strobe only
        st_d.rdata = 16'h0000;
        if (busReq.rd) begin
            if (busReq.addr == `GFC_ADDR_MODE) begin
                st_d.rdata = {14'h0000, st_q.modeSel};
            end else if (busReq.addr == `GFC_ADDR_GTIME) begin
                st_d.rdata = {14'h0000, st_q.gtimeSel};
            end else if (busReq.addr == `GFC_ADDR_CHAN) begin
                st_d.rdata = {14'h0000, st_q.chanSel};
            end else if (busReq.addr == `GFC_ADDR_STAT) begin
                st_d.rdata = {15'h0000, st_q.gateFlag};
            end else if (busReq.addr == `GFC_ADDR_DATA) begin
                // Whole word taken in one cycle, so no torn value
                st_d.rdata = st_q.count;
                st_d.xfer  = st_q.count;
            end else begin
                st_d.rdata = 16'h0000;
            end
        end
    end

    // ============================================================
    // Registers
    // Synchronous reset; every field returns to its idle value
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q          <= '0;
            st_q.fsm      <= GFC_IDLE;
            st_q.modeSel  <= `GFC_MODE_RST;
            st_q.gtimeSel <= `GFC_GTIME_RST;
            st_q.chanSel  <= `GFC_CHAN_RST;
            st_q.count    <= `GFC_COUNT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign busRdata = st_q.rdata;
    assign gateOpen = st_q.gateFlag;
    assign xferBuf  = st_q.xfer;

endmodule : gfc_freq_counter

// ---- src/gfc_ref_gen.sv ----
/*
  Internal reference frequencies of 1 kHz, 100 kHz and 900 kHz made by
  dividing mclk with phase accumulators, plus a rising-edge tick each.
  Assumes CLK_HZ is at least twice the highest reference.
*/
`timescale 1ns/1ps
`include "gfc_params.svh"

module gfc_ref_gen
    import gfc_pkg::*;
#(
    parameter int unsigned CLK_HZ = `GFC_MCLK_HZ
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // References
    output logic      [2:0] refLvl,
    output logic      [2:0] refTick
);
    localparam logic [31:0] HZ = 32'(CLK_HZ);
    localparam logic [2:0][31:0] STEP = {
        32'(2 * `GFC_REF_900K_HZ),
        32'(2 * `GFC_REF_100K_HZ),
        32'(2 * `GFC_REF_1K_HZ)
    };

    typedef struct packed {
        logic [2:0][31:0] acc;
        logic [2:0]       lvl;
        logic [2:0]       tick;
    } gfc_ref_s;

    gfc_ref_s st_q;
    gfc_ref_s st_d;

    // Fractional division keeps the mean frequency exact; 900 kHz has
    // one cycle of edge jitter, which the counter tolerates.
    always_comb begin
        logic [31:0] sum;
        sum  = '0;
        st_d = st_q;
        for (int i = 0; i < 3; i++) begin
            sum          = st_q.acc[i] + STEP[i];
            st_d.tick[i] = 1'b0;
            if (sum >= HZ) begin
                st_d.acc[i]  = sum - HZ;
                st_d.lvl[i]  = ~st_q.lvl[i];
                st_d.tick[i] = ~st_q.lvl[i];
            end else begin
                st_d.acc[i]  = sum;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign refLvl  = st_q.lvl;
    assign refTick = st_q.tick;

endmodule : gfc_ref_gen

// ---- src/gfc_sync.sv ----
/*
  Two-flop synchroniser for a group of asynchronous input pins.
  Assumes pins are unrelated to mclk; outputs are the second flop.
*/
`timescale 1ns/1ps

module gfc_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         reset_n,
    // Pins
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gfc_sync_s;

    gfc_sync_s st_q;
    gfc_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pinIn;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pinSync = st_q.s2;

endmodule : gfc_sync

// ---- tb/gfc_freq_counter_asserts.sv ----
/*
  Port checker for gfc_freq_counter, bound into every instance.
  Assumes one clock domain and register writes seen on busReq.
*/
`timescale 1ns/1ps

module gfc_freq_counter_asserts
    import gfc_pkg::*;
#(
    parameter int unsigned CLK_HZ = 25000000
) (
    // Clock and reset
    input wire logic         mclk,
    input wire logic         reset_n,
    // Watched ports
    input wire gfc_bus_req_s busReq,
    input wire logic [15:0]  busRdata,
    input wire gfc_pins_s    pins,
    input wire logic         gateOpen,
    input wire logic [15:0]  xferBuf
);
    // ==========
    // Helper state
    localparam int MAXT = 9 * (CLK_HZ / 1000) + 8;
    logic [1:0]  modeQ;
    logic [1:0]  gtQ;
    int unsigned openCnt;
    wire logic wrStart = busReq.wr && busReq.addr == 8'h23 && busReq.wdata[1];
    wire logic rdData  = busReq.rd && busReq.addr == 8'h24;
    wire logic wrClr   = busReq.wr && busReq.addr == 8'h23 && busReq.wdata[0];
    logic        rdQ;
    logic        clrSeen;
    logic [15:0] lastCnt;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            modeQ   <= 2'h0;
            gtQ     <= 2'h0;
            openCnt <= 0;
            rdQ     <= 1'b0;
            clrSeen <= 1'b1;
            lastCnt <= 16'h0;
        end else begin
            rdQ <= rdData;
            if (wrClr) clrSeen <= 1'b1;
            else if (rdQ) clrSeen <= 1'b0;
            if (rdQ) lastCnt <= busRdata;
            if (busReq.wr && busReq.addr == 8'h1E) modeQ <= busReq.wdata[1:0];
            if (busReq.wr && busReq.addr == 8'h1F) gtQ <= busReq.wdata[1:0];
            // Only timed pin gates have a bound; external gates last as long as the pin says
            openCnt <= (gateOpen && modeQ != 2'h0 && gtQ != 2'h3 && !wrStart) ? openCnt + 1 : 0;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // ==========
    // Properties
    property p_start; wrStart && gtQ != 2'h3 |=> gateOpen; endproperty
    a_start: assert property (p_start) else $error("flag not set by start");
    property p_rd_idle; !busReq.rd |=> busRdata == 16'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_stat;
        busReq.rd && busReq.addr == 8'h21 |=> busRdata == {15'h0, $past(gateOpen)};
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");
    property p_xfer; rdData |=> xferBuf == busRdata; endproperty
    a_xfer: assert property (p_xfer) else $error("buffer not loaded");
    property p_xfer_hold; !rdData |=> $stable(xferBuf); endproperty
    a_xfer_hold: assert property (p_xfer_hold) else $error("buffer changed");
    property p_clr;
        busReq.wr && busReq.addr == 8'h23 && busReq.wdata[0] ##[1:2] rdData
            |=> busRdata <= 16'h3;
    endproperty
    a_clr: assert property (p_clr) else $error("clear not applied");
    property p_open;
        busReq.wr && busReq.addr == 8'h1F && busReq.wdata[1:0] == 2'h3 && gtQ != 2'h3
            && modeQ != 2'h0 |=> gateOpen;
    endproperty
    a_open: assert property (p_open) else $error("held gate not open");
    property p_leave;
        busReq.wr && busReq.addr == 8'h1F && busReq.wdata[1:0] != 2'h3 && gtQ == 2'h3
            |=> ##[0:1] !gateOpen;
    endproperty
    a_leave: assert property (p_leave) else $error("held gate not closed");
    property p_timed; openCnt <= MAXT; endproperty
    a_timed: assert property (p_timed) else $error("timed gate too long");
    // With no clear between two count reads the value never drops, so no wrap
    property p_no_wrap; rdQ && !clrSeen |-> busRdata >= lastCnt; endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("count went down");
endmodule : gfc_freq_counter_asserts

bind gfc_freq_counter gfc_freq_counter_asserts #(.CLK_HZ(CLK_HZ)) gfc_freq_counter_asserts_inst (
    .mclk(mclk), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
    .pins(pins), .gateOpen(gateOpen), .xferBuf(xferBuf));

// ---- tb/gfc_pin_model.sv ----
/*
  Far-side pin model: a square wave on both input pins and gate pulses.
  Assumes the caller keeps pulses apart by more than their width.
*/
`timescale 1ns/1ps

module gfc_pin_model
    import gfc_pkg::*;
(
    // Control
    input wire logic sqRun,
    // Pins
    output gfc_pins_s pins
);
    // Odd start offset keeps the wave out of phase with mclk
    initial begin
        pins = '0;
        #7;
        forever begin
            #200;
            if (sqRun) begin
                pins.halvedIn = ~pins.halvedIn;
                pins.directIn = ~pins.directIn;
            end
        end
    end

    task automatic gate_pulse(input logic useB);
        if (useB) pins.gateB = 1'b1;
        else pins.gateA = 1'b1;
        #400;
        pins.gateA = 1'b0;
        pins.gateB = 1'b0;
    endtask : gate_pulse
endmodule : gfc_pin_model

// ---- tb/tb.sv ----
/*
  Self-checking bench of gfc_freq_counter with a pin model.
  Assumes CLK_HZ 2000000, so 1 ms of gate is 2000 mclk cycles.
*/
`timescale 1ns/1ps

module tb
    import gfc_pkg::*;
;
    localparam int CLK = 2000000;
    localparam int MS  = CLK / 1000;
    logic         mclk = 1'b0;
    logic         reset_n;
    gfc_bus_req_s busReq;
    logic [15:0]  busRdata;
    logic [15:0]  xferBuf;
    logic [15:0]  rd;
    gfc_pins_s    pins;
    logic         gateOpen;
    logic         sqRun;
    int           failCount = 0;
    int           checksDone = 0;
    int           n;
    int           e;
    int           expQ[$];

    always #20 mclk = ~mclk;

    gfc_freq_counter #(.CLK_HZ(CLK)) gfc_freq_counter_inst (
        .mclk(mclk), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
        .pins(pins), .gateOpen(gateOpen), .xferBuf(xferBuf));
    gfc_pin_model gfc_pin_model_inst (.sqRun(sqRun), .pins(pins));

    // ==========
    // Tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] s, input logic [15:0] x);
        checksDone++;
        if (s !== x) begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, s, x);
        end
    endtask : check

    task automatic check_in(input logic [15:0] s, input int lo, input int hi);
        check(16'(s >= lo && s <= hi), 16'h1);
    endtask : check_in

    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        busReq <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        busReq <= '0;
        #1 rd = busRdata;
    endtask : bus

    task automatic wait_close(input int lim);
        n = 0;
        while (gateOpen !== 1'b0 && n < lim) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= lim) begin
            failCount++;
            $display("Error at %0t: gate stuck open", $time);
            report_and_stop();
        end
    endtask : wait_close

    // ==========
    // Main sequence
    int tm[5] = '{1, 1, 1, 2, 3};
    int tg[5] = '{0, 1, 2, 0, 0};
    int tl[5] = '{1, 4, 8, 1, 1};
    int rf[3] = '{1000, 100000, 900000};
    logic [7:0] ra[7] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h23, 8'h24, 8'h30};
    initial begin
        reset_n = 1'b0;
        busReq  = '0;
        sqRun   = 1'b0;
        void'($urandom(32'hCEEC));
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (ra[i]) begin
            bus(0, ra[i], 16'h0);
            check(rd, 16'h0);
        end
        e = ($urandom & 32'hFFFC) | ($urandom % 3);
        // Start bit kept low: a gate armed here would spoil the status read-back
        foreach (ra[i]) begin
            bus(1, ra[i], 16'(ra[i] == 8'h23 ? e & 32'hFFFD : e));
            expQ.push_back(ra[i] < 8'h21 ? e & 3 : 0);
        end
        for (int i = 0; i < 7; i++) begin
            bus(0, ra[i], 16'h0);
            check(rd, 16'(expQ.pop_front()));
        end
        $display("test registers done");
        sqRun <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus(1, 8'h1E, 16'(tm[i]));
            bus(1, 8'h1F, 16'(tg[i]));
            repeat (50) @(posedge mclk);
            bus(1, 8'h23, 16'h1);
            bus(1, 8'h23, 16'h2);
            check(gateOpen, 1'b1);
            wait_close((tl[i] + 1) * MS + 20);
            check_in(16'(n), tl[i] * MS - 2, (tl[i] + 1) * MS + 5);
            e = 200 * tl[i] / (tm[i] == 2 ? 2 : 1);
            bus(0, 8'h24, 16'h0);
            check_in(rd, e - 1, e + 1);
            check(xferBuf, rd);
        end
        $display("test timed gate done");
        bus(1, 8'h1F, 16'h3);
        check(gateOpen, 1'b1);
        repeat (300) @(posedge mclk);
        bus(1, 8'h23, 16'h1);
        bus(0, 8'h24, 16'h0);
        check_in(rd, 0, 1);
        repeat (198) @(posedge mclk);
        bus(0, 8'h24, 16'h0);
        check_in(rd, 19, 22);
        bus(1, 8'h1E, 16'h0);
        bus(1, 8'h23, 16'h1);
        repeat (100) @(posedge mclk);
        bus(0, 8'h24, 16'h0);
        check({rd[14:0], gateOpen}, 16'h1);
        bus(1, 8'h1F, 16'h0);
        @(posedge mclk);
        #1 check(gateOpen, 1'b0);
        $display("test held gate done");
        sqRun <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            bus(1, 8'h20, 16'(r % 2 + 1));
            bus(1, 8'h1F, 16'(r));
            bus(1, 8'h23, 16'h1);
            bus(1, 8'h23, 16'h2);
            check(gateOpen, 1'b1);
            gfc_pin_model_inst.gate_pulse(r == 1);
            repeat (4990) @(posedge mclk);
            #1 check(gateOpen, 1'b1);
            gfc_pin_model_inst.gate_pulse(r == 1);
            wait_close(40);
            e = rf[r] / 1000 * 5 / 2;
            bus(0, 8'h24, 16'h0);
            check_in(rd, e - 2, e + 3);
        end
        $display("test external gate done");
        report_and_stop();
    end
endmodule : tb
